// *** csmc_pkg.sv ***
// Package: constants and types for the configuration source and mode control block
package csmc_pkg;

    // ==========================================================
    // Register offsets (byte offsets on the plain register port)
    localparam logic [7:0] REG_OVERRIDE = 8'h02;  // Override bits
    localparam logic [7:0] REG_ENABLE = 8'h06;    // Register enable
    localparam logic [7:0] REG_SIGDET = 8'h0A;    // Signal detect status
    localparam logic [7:0] REG_MODE = 8'h0B;      // Mode and address status
    localparam logic [7:0] REG_RX_DETECT_SELECT = 8'h0C;     // Receiver detect setting
    localparam logic [7:0] REG_SDTH = 8'h0D;      // Signal detect threshold
    localparam logic [7:0] REG_CH_BASE = 8'h10;   // First per-channel register

    // ==========================================================
    // Field positions
    localparam int REG_EN_BIT = 3;       // Register enable in REG_ENABLE
    localparam int OVR_RX_DETECT_SELECT_BIT = 0;    // Override of rx detect pin
    localparam int OVR_SDTH_BIT = 1;     // Override of threshold pin

    // ==========================================================
    // Reset values of per-channel, rx detect and threshold settings
    localparam logic [1:0] EQ_RESET = 2'h2;     // Equalizer default
    localparam logic [2:0] SWING_RESET = 3'h6;  // Output swing default
    localparam logic [1:0] RX_DETECT_SELECT_RESET = 2'h2;  // Auto detect default (F)
    localparam logic [1:0] SDTH_RESET = 2'h0;   // Threshold default (F)

    // ==========================================================
    // Slave address base; the step of 2 is applied where the address is built
    localparam logic [7:0] SLAVE_ADDR_BASE = 8'hB0;

    // ==========================================================
    // Four-level thresholds in thousandths of supply
    localparam int TH_0R_MILLI = 200;
    localparam int TH_RF_MILLI = 500;
    localparam int TH_F1_MILLI = 800;

    // ==========================================================
    // Timing
    localparam int CLK_HZ = 10_000_000;
    localparam int SCL_NOM_HZ = 400_000;
    localparam int SCL_MIN_HZ = 280_000;
    localparam int SCL_MAX_HZ = 520_000;
    // Half period of serial clock, in cycles (13 -> 384.6 kHz, inside range)
    localparam int SCL_HALF_CYC = (CLK_HZ + 2 * SCL_NOM_HZ - 1) / (2 * SCL_NOM_HZ);
    localparam int POR_READY_MS = 500;
    localparam int POR_READY_CYC = (CLK_HZ / 1000) * POR_READY_MS;

    // ==========================================================
    // Types
    typedef enum logic [1:0] {
        CSMC_LVL_0,
        CSMC_LVL_R,
        CSMC_LVL_F,
        CSMC_LVL_1
    } csmc_level_t;

    typedef enum logic [1:0] {
        CSMC_MODE_PIN,
        CSMC_MODE_SLAVE,
        CSMC_MODE_MASTER
    } csmc_mode_t;

    // One channel's applied settings
    typedef struct packed {
        logic [1:0] eq;
        logic [2:0] swing;
        logic term_off;
    } csmc_chan_t;

endpackage

// *** csmc_level_decode.sv ***
// Four-level pin decoder: compares a sampled pin voltage to supply fractions
`timescale 1ns/1ps

module csmc_level_decode #(
    parameter int WIDTH = 10
) (
    // Pin voltage as a fraction of supply, full scale = all ones
    input wire logic [WIDTH-1:0] pin_code,
    // Decoded level
    output csmc_pkg::csmc_level_t level
);

    // ==========================================================
    // Thresholds scaled to code range
    localparam logic [WIDTH+9:0] FULL = (WIDTH+10)'((1 << WIDTH) - 1);
    localparam logic [WIDTH+9:0] T0 = (WIDTH+10)'(csmc_pkg::TH_0R_MILLI);
    localparam logic [WIDTH+9:0] T1 = (WIDTH+10)'(csmc_pkg::TH_RF_MILLI);
    localparam logic [WIDTH+9:0] T2 = (WIDTH+10)'(csmc_pkg::TH_F1_MILLI);
    localparam logic [WIDTH+9:0] MILLE = (WIDTH+10)'(1000);

    logic [WIDTH+9:0] scaled; // Pin code times 1000

    // Compare against 0.2, 0.5 and 0.8 of full scale
    always_comb begin
        scaled = (WIDTH+10)'(pin_code) * MILLE;
        if (scaled < T0 * FULL) begin
            level = csmc_pkg::CSMC_LVL_0;
        end else if (scaled < T1 * FULL) begin
            level = csmc_pkg::CSMC_LVL_R;
        end else if (scaled < T2 * FULL) begin
            level = csmc_pkg::CSMC_LVL_F;
        end else begin
            level = csmc_pkg::CSMC_LVL_1;
        end
    end

endmodule

// *** csmc_top.sv ***
// Configuration source and mode control: picks pin, register or loaded settings
`timescale 1ns/1ps

module csmc_top #(
    parameter int CHANNELS = 8,
    parameter int PIN_W = 10,
    parameter int POR_CYC = csmc_pkg::POR_READY_CYC
) (
    input wire logic clk,
    input wire logic reset_n,
    // Mode pin: high-side and open detection from the pad
    input wire logic [PIN_W-1:0] config_source_select,
    // Four-level control pins, equalizer A/B, swing A1/A0/B1/B0
    input wire logic [PIN_W-1:0] equalizer_level_pin_a,
    input wire logic [PIN_W-1:0] equalizer_level_pin_b,
    input wire logic [PIN_W-1:0] output_swing_pin_a1,
    input wire logic [PIN_W-1:0] output_swing_pin_a0,
    input wire logic [PIN_W-1:0] output_swing_pin_b1,
    input wire logic [PIN_W-1:0] output_swing_pin_b0,
    input wire logic [PIN_W-1:0] rx_detect_select,
    input wire logic [PIN_W-1:0] signal_detect_threshold,
    input wire logic power_down_pin,
    // Per-channel signal detect status from the analog front end
    input wire logic [CHANNELS-1:0] sig_assert,
    input wire logic [CHANNELS-1:0] sig_deassert,
    // EEPROM load finished (from the serial master engine)
    input wire logic load_done,
    // Register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // Applied settings
    output csmc_pkg::csmc_chan_t [CHANNELS-1:0] chan_cfg,
    output logic [1:0] rx_detect_mode,
    output logic [1:0] sd_threshold,
    output logic channels_off,
    output csmc_pkg::csmc_mode_t mode,
    output logic [7:0] slave_address,
    output logic bus_master_active,
    output logic scl_enable,
    output logic ready
);

    // ==========================================================
    // Pin decoding
    csmc_pkg::csmc_level_t lvl [8]; // Decoded levels of the mode, setting and rx detect pins (threshold pin decoded apart)
    logic [PIN_W-1:0] pins [8];     // Raw pin codes

    always_comb begin
        pins[0] = config_source_select;
        pins[1] = equalizer_level_pin_a;
        pins[2] = equalizer_level_pin_b;
        pins[3] = output_swing_pin_a1;
        pins[4] = output_swing_pin_a0;
        pins[5] = output_swing_pin_b1;
        pins[6] = output_swing_pin_b0;
        pins[7] = rx_detect_select;
    end

    // One decoder per pin
    for (genvar g = 0; g < 8; g++) begin : g_dec
        csmc_level_decode #(.WIDTH(PIN_W)) u_dec (
            .pin_code(pins[g]),
            .level(lvl[g])
        );
    end

    csmc_pkg::csmc_level_t lvl_sdth; // Threshold pin level
    csmc_level_decode #(.WIDTH(PIN_W)) u_dec_sdth (
        .pin_code(signal_detect_threshold),
        .level(lvl_sdth)
    );

    // Maps a two-pin swing code to a swing setting (levels 1..6)
    function automatic logic [2:0] swing_of(csmc_pkg::csmc_level_t hi,
                                            csmc_pkg::csmc_level_t lo);
        logic [3:0] key;
        key = {hi, lo};
        unique case (key)
            4'h0: swing_of = 3'h1;
            4'h1: swing_of = 3'h2;
            4'h3: swing_of = 3'h3;
            4'h6: swing_of = 3'h4;
            4'h9: swing_of = 3'h5;
            4'hC: swing_of = 3'h6;
            default: swing_of = csmc_pkg::SWING_RESET;
        endcase
    endfunction

    // Maps threshold pin level to register encoding
    function automatic logic [1:0] sdth_of(csmc_pkg::csmc_level_t l);
        unique case (l)
            csmc_pkg::CSMC_LVL_0: sdth_of = 2'h2;
            csmc_pkg::CSMC_LVL_R: sdth_of = 2'h1;
            csmc_pkg::CSMC_LVL_F: sdth_of = 2'h0;
            csmc_pkg::CSMC_LVL_1: sdth_of = 2'h3;
        endcase
    endfunction

    // ==========================================================
    // Mode selection, combinational so the switch is immediate
    logic load_fin; // Sticky: EEPROM load completed

    always_comb begin
        unique case (lvl[0])
            csmc_pkg::CSMC_LVL_0: mode = csmc_pkg::CSMC_MODE_PIN;
            csmc_pkg::CSMC_LVL_1: mode = csmc_pkg::CSMC_MODE_SLAVE;
            default: mode = load_fin ? csmc_pkg::CSMC_MODE_SLAVE
                                     : csmc_pkg::CSMC_MODE_MASTER;
        endcase
    end

    // Load completion latched; leaving open mode rearms it
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            load_fin <= 1'b0;
        end else if (lvl[0] != csmc_pkg::CSMC_LVL_F) begin
            load_fin <= 1'b0;
        end else if (load_done) begin
            load_fin <= 1'b1;
        end
    end

    // Master drives the bus once ready, until a load completes with the mode pin at F (at R it never stops)
    assign bus_master_active = (mode == csmc_pkg::CSMC_MODE_MASTER) && ready;

    // ==========================================================
    // Slave address from the reused setting pins
    logic [3:0] addr_code; // Address input code
    always_comb begin
        addr_code = {lvl[1] != csmc_pkg::CSMC_LVL_0, lvl[2] != csmc_pkg::CSMC_LVL_0,
                     lvl[3] != csmc_pkg::CSMC_LVL_0, lvl[4] != csmc_pkg::CSMC_LVL_0};
        slave_address = csmc_pkg::SLAVE_ADDR_BASE + {3'h0, addr_code, 1'b0};
    end

    // ==========================================================
    // Serial clock divider: half-period enable pulse
    logic [4:0] scl_cnt; // Half period counter
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            scl_cnt <= 5'h0;
        end else if (!bus_master_active || scl_cnt == 5'(csmc_pkg::SCL_HALF_CYC - 1)) begin
            scl_cnt <= 5'h0;
        end else begin
            scl_cnt <= scl_cnt + 5'h1;
        end
    end
    assign scl_enable = bus_master_active && scl_cnt == 5'(csmc_pkg::SCL_HALF_CYC - 1);

    // ==========================================================
    // Power-on ready counter
    logic [31:0] por_cnt; // Cycles since reset release
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            por_cnt <= 32'h0;
            ready <= 1'b0;
        end else if (!ready) begin
            por_cnt <= por_cnt + 32'h1;
            ready <= por_cnt >= 32'(POR_CYC - 1);
        end
    end

    // ==========================================================
    // Registers
    logic reg_en;                        // Register enable
    logic [1:0] ovr;                     // Override bits
    logic [1:0] rx_detect_select_reg;               // Rx detect register value
    logic [1:0] sdth_reg;                // Threshold register value
    csmc_pkg::csmc_chan_t ch_reg [CHANNELS]; // Per-channel settings
    logic wr_ok;                         // Register writes accepted
    // Register writes take effect only in slave mode and once ready; reads answer in any mode
    assign wr_ok = reg_write && ready && mode == csmc_pkg::CSMC_MODE_SLAVE;

    // Enable and override bits; pin mode clears overrides
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_en <= 1'b0;
            ovr <= 2'h0;
        end else if (mode == csmc_pkg::CSMC_MODE_PIN) begin
            ovr <= 2'h0;
        end else if (wr_ok && reg_addr == csmc_pkg::REG_ENABLE) begin
            reg_en <= reg_wdata[csmc_pkg::REG_EN_BIT];
        end else if (wr_ok && reg_addr == csmc_pkg::REG_OVERRIDE && reg_en) begin
            ovr <= {reg_wdata[csmc_pkg::OVR_SDTH_BIT], reg_wdata[csmc_pkg::OVR_RX_DETECT_SELECT_BIT]};
        end
    end

    // Setting registers change only after enable; power down ignored
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            rx_detect_select_reg <= csmc_pkg::RX_DETECT_SELECT_RESET;
            sdth_reg <= csmc_pkg::SDTH_RESET;
            for (int i = 0; i < CHANNELS; i++) begin
                ch_reg[i] <= '{csmc_pkg::EQ_RESET, csmc_pkg::SWING_RESET, 1'b0};
            end
        end else if (wr_ok && reg_en) begin
            if (reg_addr == csmc_pkg::REG_RX_DETECT_SELECT) begin
                rx_detect_select_reg <= reg_wdata[1:0];
            end
            if (reg_addr == csmc_pkg::REG_SDTH) begin
                sdth_reg <= reg_wdata[1:0];
            end
            // One register per channel
            for (int i = 0; i < CHANNELS; i++) begin
                if (reg_addr == csmc_pkg::REG_CH_BASE + 8'(i)) begin
                    ch_reg[i] <= '{reg_wdata[1:0], reg_wdata[4:2], reg_wdata[5]};
                end
            end
        end
    end

    // ==========================================================
    // Applied settings
    always_comb begin
        for (int i = 0; i < CHANNELS; i++) begin
            if (mode == csmc_pkg::CSMC_MODE_PIN) begin
                // Group A is the lower half
                if (i < CHANNELS / 2) begin
                    chan_cfg[i] = '{lvl[1], swing_of(lvl[3], lvl[4]), 1'b0};
                end else begin
                    chan_cfg[i] = '{lvl[2], swing_of(lvl[5], lvl[6]), 1'b0};
                end
            end else begin
                chan_cfg[i] = ch_reg[i];
            end
        end
        // Pin rules unless overridden
        // Pin mode follows the pins at once, before the override clear lands
        rx_detect_mode = (ovr[0] && mode != csmc_pkg::CSMC_MODE_PIN) ? rx_detect_select_reg : lvl[7];
        sd_threshold = (ovr[1] && mode != csmc_pkg::CSMC_MODE_PIN) ? sdth_reg
                                                                    : sdth_of(lvl_sdth);
    end

    assign channels_off = power_down_pin;

    // ==========================================================
    // Read data, valid in the cycle after the read strobe
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= 8'h0;
        end else if (reg_read) begin
            reg_rdata <= 8'h0;
            if (reg_addr == csmc_pkg::REG_ENABLE) begin
                reg_rdata[csmc_pkg::REG_EN_BIT] <= reg_en;
            end else if (reg_addr == csmc_pkg::REG_OVERRIDE) begin
                reg_rdata[1:0] <= ovr;
            end else if (reg_addr == csmc_pkg::REG_SIGDET) begin
                reg_rdata <= {sig_deassert[3:0], sig_assert[3:0]};
            end else if (reg_addr == csmc_pkg::REG_MODE) begin
                reg_rdata <= {2'h0, addr_code, mode};
            end else if (reg_addr == csmc_pkg::REG_RX_DETECT_SELECT) begin
                reg_rdata[1:0] <= rx_detect_mode;
            end else if (reg_addr == csmc_pkg::REG_SDTH) begin
                reg_rdata[1:0] <= sd_threshold;
            end else begin
                for (int i = 0; i < CHANNELS; i++) begin
                    if (reg_addr == csmc_pkg::REG_CH_BASE + 8'(i)) begin
                        reg_rdata <= {2'h0, ch_reg[i].term_off, ch_reg[i].swing, ch_reg[i].eq};
                    end
                end
            end
        end
    end

    // ==========================================================
    // Checks
    default clocking @(posedge clk); endclocking
    default disable iff (!reset_n);

    // Settings locked while the register enable is clear
    sequence s_locked;
        !reg_en;
    endsequence

    mode_pin_a: assert property (lvl[0] == csmc_pkg::CSMC_LVL_0 |-> mode == csmc_pkg::CSMC_MODE_PIN)
        else $error("pin level low without pin mode");
    group_set_a: assert property (mode == csmc_pkg::CSMC_MODE_PIN |-> chan_cfg[0].eq == lvl[1])
        else $error("group A equalizer not from pin");
    reg_take_a: assert property (mode == csmc_pkg::CSMC_MODE_SLAVE |-> chan_cfg[1] == ch_reg[1])
        else $error("slave mode not using registers");
    hold_dflt_a: assert property (s_locked |=> $stable(rx_detect_select_reg) && $stable(ch_reg[0]))
        else $error("setting changed without enable");
    addr_map_a: assert property (slave_address == 8'hB0 + {3'h0, addr_code, 1'b0})
        else $error("slave address wrong");
    ovr_clr_a: assert property (mode == csmc_pkg::CSMC_MODE_PIN |=> ovr == 2'h0)
        else $error("override survives pin mode");
    rx_pin_a: assert property (!ovr[0] || mode == csmc_pkg::CSMC_MODE_PIN
        |-> rx_detect_mode == lvl[7])
        else $error("rx detect pin not in effect");
    power_down_pin_keep_a: assert property ($rose(power_down_pin) && !wr_ok |=> $stable(ch_reg[0]))
        else $error("power down disturbed registers");
    scl_rate_a: assert property (scl_enable |=> !scl_enable [*8])
        else $error("serial clock too fast");
    not_ready_a: assert property ($fell(reset_n) or !ready |-> !bus_master_active)
        else $error("master active before ready");

endmodule

// *** csmc_eeprom_model.sv ***
// Configuration memory model on the far side of the serial master
`timescale 1ns/1ps

module csmc_eeprom_model (
    input wire logic clk,
    input wire logic reset_n,
    input wire logic bus_master_active,
    input wire logic scl_enable,
    input wire logic [7:0] load_len,
    output logic load_done
);
    // ==========================================================
    // Load progress
    logic [7:0] count; // Serial clock pulses seen in this load

    // A long length stands for a slow or large image, a short one for a prompt load
    always_ff @(posedge clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= 8'h00;
            load_done <= 1'b0;
        end else if (!bus_master_active) begin
            // Bus released: rearm for the next load
            count <= 8'h00;
            load_done <= 1'b0;
        end else begin
            // Finish flag stays up until the master lets go
            if (scl_enable && count != load_len) begin
                count <= count + 8'h01;
            end
            load_done <= (count == load_len);
        end
    end
endmodule

// *** testbench.sv ***
// Self-checking bench for the configuration source and mode control block
`timescale 1ns/1ps

module testbench;
    // ==========================================================
    // Settings and signals
    localparam int POR = 20; // Shortened power-on wait
    localparam int CH = 8;
    localparam logic [9:0] L0 = 10'h000; // Tied low
    localparam logic [9:0] LR = 10'h155; // One third of supply
    localparam logic [9:0] LF = 10'h2AA; // Open pin
    localparam logic [9:0] L1 = 10'h3FF; // Tied high
    logic clk, reset_n, power_down_pin, reg_write, reg_read, load_done;
    logic [9:0] mode_pin, eq_a, eq_b, sw_a1, sw_a0, sw_b1, sw_b0, rxd_pin, sdth_pin;
    logic [CH-1:0] sig_on, sig_off; // Detect status from the front end
    logic [7:0] reg_addr, reg_wdata, reg_rdata, slave_address, load_len;
    csmc_pkg::csmc_chan_t [CH-1:0] chan_cfg;
    csmc_pkg::csmc_mode_t mode;
    logic [1:0] rx_detect_mode, sd_threshold;
    logic channels_off, bus_master_active, scl_enable, ready;
    int n_mismatch = 0;
    int samples_checked = 0;
    logic [31:0] seed = 32'hFFB36FFA;
    logic [9:0] s1_tab [6] = '{L0, L0, L0, LR, LF, L1}; // Swing pin pairs for levels 1..6
    logic [9:0] s0_tab [6] = '{L0, LR, L1, LF, LR, L0};
    logic [9:0] bnd [6] = '{10'h0CC, 10'h0CD, 10'h1FF, 10'h200, 10'h332, 10'h333}; // Edges
    logic [1:0] sd_map [4] = '{2'h2, 2'h1, 2'h0, 2'h3}; // Threshold code per level
    logic [5:0] chan_val [CH]; // Values written per channel

    csmc_top #(.CHANNELS(CH), .PIN_W(10), .POR_CYC(POR)) uut (
        .clk(clk), .reset_n(reset_n), .config_source_select(mode_pin),
        .equalizer_level_pin_a(eq_a), .equalizer_level_pin_b(eq_b),
        .output_swing_pin_a1(sw_a1), .output_swing_pin_a0(sw_a0),
        .output_swing_pin_b1(sw_b1), .output_swing_pin_b0(sw_b0),
        .rx_detect_select(rxd_pin), .signal_detect_threshold(sdth_pin),
        .power_down_pin(power_down_pin), .sig_assert(sig_on), .sig_deassert(sig_off),
        .load_done(load_done), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .chan_cfg(chan_cfg), .rx_detect_mode(rx_detect_mode), .sd_threshold(sd_threshold),
        .channels_off(channels_off), .mode(mode), .slave_address(slave_address),
        .bus_master_active(bus_master_active), .scl_enable(scl_enable), .ready(ready));

    csmc_eeprom_model eeprom (.clk(clk), .reset_n(reset_n), .bus_master_active(bus_master_active),
        .scl_enable(scl_enable), .load_len(load_len), .load_done(load_done));

    // ==========================================================
    // Helpers
    // Free-running clock, 100 ns period
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    // Next pseudo-random word
    function automatic logic [31:0] rnd();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed;
    endfunction

    // Level a pin code decodes to; no code sits exactly on a threshold
    function automatic logic [1:0] lvl(input logic [9:0] c);
        int v;
        v = int'(c) * 1000;
        if (v < 200 * 1023) return 2'h0;
        if (v < 500 * 1023) return 2'h1;
        if (v < 800 * 1023) return 2'h2;
        return 2'h3;
    endfunction

    // Register byte layout to applied settings
    function automatic csmc_pkg::csmc_chan_t cfg_of(input logic [5:0] r);
        return {r[1:0], r[4:2], r[5]};
    endfunction

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1; // Host keeps its bus at or under 400 kHz
        @(posedge clk);
        reg_write <= 1'b0;
    endtask

    // Read strobe; data only in the following cycle
    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
        @(posedge clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk);
        reg_read <= 1'b0;
        @(negedge clk);
        chk(reg_rdata & m, e);
    endtask

    task automatic set_mode(input logic [9:0] m);
        @(posedge clk);
        mode_pin <= m;
        @(negedge clk);
    endtask

    // Reset, with a write tried before the block is ready
    task automatic do_reset();
        reset_n <= 1'b0;
        repeat (16) @(posedge clk);
        reset_n <= 1'b1;
        @(negedge clk);
        chk(ready, 1'b0);
        wr(csmc_pkg::REG_ENABLE, 8'h08);
        for (int i = 0; i < POR + 4 && ready !== 1'b1; i++) @(negedge clk);
        chk(ready, 1'b1);
        chk(chan_cfg[0], 6'h2C);
        rdchk(csmc_pkg::REG_ENABLE, 8'h08, 8'h00);
        rdchk(csmc_pkg::REG_OVERRIDE, 8'h03, 8'h00);
        rdchk(csmc_pkg::REG_CH_BASE, 8'h3F, 8'h1A);
        $display("test reset finished");
    endtask

    task automatic final_report();
        $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
        if (n_mismatch == 0 && samples_checked > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    // Watchdog well beyond the fewer than one thousand cycles the tests need
    initial begin
        repeat (20000) @(posedge clk);
        n_mismatch++;
        final_report();
    end

    // ==========================================================
    // Main sequence
    initial begin
        {reset_n, power_down_pin, reg_write, reg_read, reg_addr, reg_wdata} = '0;
        {eq_a, eq_b, sw_a0, sw_a1, sw_b0, sw_b1, rxd_pin, sdth_pin} = '0;
        {sig_on, sig_off, load_len} = '0;
        mode_pin = L1;
        do_reset();
        // Pin mode: random codes, decoder edges first
        set_mode(L0);
        chk(mode, csmc_pkg::CSMC_MODE_PIN);
        wr(csmc_pkg::REG_ENABLE, 8'h08);
        for (int i = 0; i < 16; i++) begin
            int a;
            int b;
            a = rnd() % 6;
            b = rnd() % 6;
            @(posedge clk);
            eq_a <= 10'(rnd());
            eq_b <= 10'(rnd());
            sw_a1 <= s1_tab[a];
            sw_a0 <= s0_tab[a];
            sw_b1 <= s1_tab[b];
            sw_b0 <= s0_tab[b];
            rxd_pin <= (i < 6) ? bnd[i] : 10'(rnd());
            sdth_pin <= 10'(rnd());
            sig_on <= CH'(rnd());
            sig_off <= CH'(rnd());
            @(negedge clk);
            for (int c = 0; c < CH; c++) begin
                chk(chan_cfg[c].eq, lvl(c < CH / 2 ? eq_a : eq_b));
                chk(chan_cfg[c].swing, (c < CH / 2 ? a : b) + 1);
            end
            chk(rx_detect_mode, lvl(rxd_pin));
            chk(sd_threshold, sd_map[lvl(sdth_pin)]);
            rdchk(csmc_pkg::REG_SIGDET, 8'hFF, {sig_off[3:0], sig_on[3:0]});
        end
        $display("test pin mode finished");
        // Slave mode: address from pins, settings held at defaults
        set_mode(L1);
        chk(mode, csmc_pkg::CSMC_MODE_SLAVE);
        rdchk(csmc_pkg::REG_ENABLE, 8'h08, 8'h00);
        for (int k = 0; k < 16; k++) begin
            @(posedge clk);
            eq_a <= k[3] ? (10'(rnd()) | 10'h200) : L0;
            eq_b <= k[2] ? L1 : L0;
            sw_a1 <= k[1] ? LF : L0;
            sw_a0 <= k[0] ? LR : L0;
            @(negedge clk);
            chk(slave_address, 8'hB0 + 8'(2 * k));
            chk(chan_cfg[0], 6'h2C);
        end
        wr(csmc_pkg::REG_CH_BASE, 8'h3F);
        @(negedge clk);
        chk(chan_cfg[0], 6'h2C);
        wr(csmc_pkg::REG_ENABLE, 8'h08);
        for (int c = 0; c < CH; c++) begin
            chan_val[c] = 6'(rnd());
            wr(csmc_pkg::REG_CH_BASE + 8'(c), {2'h0, chan_val[c]});
        end
        @(posedge clk);
        power_down_pin <= 1'b1;
        @(negedge clk);
        for (int c = 0; c < CH; c++) begin
            chk(chan_cfg[c], cfg_of(chan_val[c]));
            rdchk(csmc_pkg::REG_CH_BASE + 8'(c), 8'h3F, {2'h0, chan_val[c]});
        end
        chk(channels_off, 1'b1);
        $display("test slave registers finished");
        // Overrides of the detect and threshold pins
        @(posedge clk);
        power_down_pin <= 1'b0;
        rxd_pin <= LR;
        sdth_pin <= LF;
        wr(csmc_pkg::REG_RX_DETECT_SELECT, 8'h03);
        wr(csmc_pkg::REG_SDTH, 8'h01);
        @(negedge clk);
        chk(rx_detect_mode, 2'h1);
        chk(sd_threshold, 2'h0);
        wr(csmc_pkg::REG_OVERRIDE, 8'h03);
        @(posedge clk);
        rxd_pin <= L0;
        sdth_pin <= L1;
        @(negedge clk);
        chk(rx_detect_mode, 2'h3);
        chk(sd_threshold, 2'h1);
        set_mode(L0);
        chk(rx_detect_mode, 2'h0);
        chk(sd_threshold, 2'h3);
        set_mode(L1);
        chk(sd_threshold, 2'h3);
        rdchk(csmc_pkg::REG_OVERRIDE, 8'h03, 8'h00);
        $display("test overrides finished");
        wr(csmc_pkg::REG_ENABLE, 8'h08);
        do_reset();
        // Master mode: prompt load, then a slow one
        for (int p = 0; p < 2; p++) begin
            int n;
            load_len <= p ? 8'h28 : 8'h02;
            set_mode(LF);
            chk(mode, csmc_pkg::CSMC_MODE_MASTER);
            chk(bus_master_active, 1'b1);
            n = 0;
            while (scl_enable !== 1'b1 && n < 40) begin
                @(negedge clk);
                n++;
            end
            n = 0;
            do begin
                @(negedge clk);
                n++;
            end while (scl_enable !== 1'b1 && n < 40);
            chk(n, csmc_pkg::SCL_HALF_CYC);
            chk(csmc_pkg::CLK_HZ / (2 * n) >= csmc_pkg::SCL_MIN_HZ, 1'b1);
            chk(csmc_pkg::CLK_HZ / (2 * n) <= csmc_pkg::SCL_MAX_HZ, 1'b1);
            n = 0;
            while (mode !== csmc_pkg::CSMC_MODE_SLAVE && n < 1000) begin
                @(negedge clk);
                n++;
            end
            chk(mode, csmc_pkg::CSMC_MODE_SLAVE);
            chk(bus_master_active, 1'b0);
            set_mode(L0);
        end
        $display("test master load finished");
        final_report();
    end
endmodule
